// >>> core/adc_ctrl_defines.svh
// register offsets, field positions and timing counts of the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define OFS_MISC     8'h77
`define OFS_RES_LO   8'h78
`define OFS_RES_HI   8'h79
`define OFS_CTRL     8'h7a
`define OFS_TRIG     8'h7b
`define OFS_MUX      8'h7c
`define REG_RESET    8'h00
`define CS_EN        7
`define CS_START     6
`define CS_ATE       5
`define CS_DONE      4
`define CS_IE        3
`define CS_PS_HI     2
`define MX_REF_HI    7
`define MX_REF_LO    6
`define MX_LEFT      5
`define MX_SEL_HI    4
`define MX_DIFF      4
`define MISC_AREF    2
`define TRIG_HI      2
`define TRIG_FREE    3'h0
`define LEN_NORMAL   5'h0d
`define LEN_LONG     5'h19
`define PS_W         7
`define SEL_GND      4'he
`endif

// >>> core/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    REF_SUPPLY = 2'h0,
    REF_EXT    = 2'h1,
    REF_INT11  = 2'h2,
    REF_INT256 = 2'h3
  } ref_t;
  typedef enum logic [2:0] {
    SRC_PIN    = 3'h0,
    SRC_TEMP   = 3'h1,
    SRC_GAP    = 3'h2,
    SRC_QUART  = 3'h3,
    SRC_GND    = 3'h4,
    SRC_NONE   = 3'h5
  } src_t;
  typedef struct packed {
    ref_t       vref;
    src_t       src;
    logic       diff;
    logic       gain_20x;
    logic [3:0] pos_pin;
    logic [3:0] neg_pin;
  } analog_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } state_t;
endpackage : adc_ctrl_pkg

// >>> core/adc_control_registers.sv
// converter control and status registers with conversion sequencer and prescaler
//
// The strobed register port was chosen for this implementation.
`include "adc_ctrl_defines.svh"
module adc_control_registers
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // cpu interrupt side
  input  wire logic        irq_global_en,
  input  wire logic        irq_ack,
  output logic             irq_req,
  // trigger sources, index 0 unused
  input  wire logic [7:0]  trig_in,
  // conversion core
  input  wire logic [9:0]  core_result,
  output analog_sel_t      analog_sel,
  output logic             conv_power,
  output logic             conv_tick,
  output logic             conv_busy,
  output logic             conv_long
);

  // ==========================================================
  // decode helpers
  function automatic logic [`PS_W-1:0] div_last(input logic [2:0] ps);
    logic [`PS_W-1:0] v;
    v = '0;
    if (ps == 3'h0) begin
      v = `PS_W'(1);
    end else begin
      v = `PS_W'((1 << ps) - 1);
    end
    return v;
  endfunction : div_last

  function automatic analog_sel_t decode_sel(input logic [1:0] rc,
                                             input logic aref,
                                             input logic [4:0] code);
    analog_sel_t s;
    logic [3:0]  p;
    s = '0;
    if (!rc[0]) begin
      s.vref = aref ? REF_EXT : REF_SUPPLY;
    end else begin
      s.vref = rc[1] ? REF_INT256 : REF_INT11;
    end
    if (code[`MX_DIFF]) begin
      // differential pairs
      // pairs skip one pin after every third pair
      p = {1'b0, code[3:1]}
        + ((code[3:1] >= 3'h3) ? 4'h1 : 4'h0)
        + ((code[3:1] >= 3'h6) ? 4'h1 : 4'h0);
      s.src      = SRC_PIN;
      s.diff     = 1'b1;
      s.gain_20x = code[0];
      s.pos_pin  = p;
      s.neg_pin  = p + 4'h1;
    end else begin
      s.pos_pin = code[3:0];
      if (code[3:0] <= 4'ha) begin
        s.src = SRC_PIN;
      end else if (code[3:0] == 4'hb) begin
        s.src = SRC_TEMP;
      end else if (code[3:0] == 4'hc) begin
        s.src = SRC_GAP;
      end else if (code[3:0] == 4'hd) begin
        s.src = SRC_QUART;
      end else if (code[3:0] == `SEL_GND) begin
        s.src = SRC_GND;
      end else begin
        s.src = SRC_NONE;
      end
    end
    return s;
  endfunction : decode_sel

  // ==========================================================
  // programmed fields
  logic        en_q, ate_q, ie_q, left_q, aref_q, done_q;
  logic [2:0]  ps_q, tsel_q;
  logic [1:0]  ref_q, act_ref_q;
  logic [4:0]  sel_q;
  logic [9:0]  result_q;
  logic        lock_q;
  state_t      state_q;
  logic [4:0]  cnt_q;
  logic [`PS_W-1:0] pre_q;
  logic        first_q, ref_chg_q, trig_prev_q;

  logic wr_ctrl, wr_mux, wr_misc, wr_trig, en_d;
  logic idle, end_conv, apply_now, ref_differs;
  logic start_sw, start_trig, start_free, start_any;
  logic trig_level, trig_edge, lock_blocks;

  assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
  assign wr_mux  = reg_wr && (reg_addr == `OFS_MUX);
  assign wr_misc = reg_wr && (reg_addr == `OFS_MISC);
  assign wr_trig = reg_wr && (reg_addr == `OFS_TRIG);
  assign en_d    = wr_ctrl ? reg_wdata[`CS_EN] : en_q;
  assign idle    = (state_q == ST_IDLE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_q  <= 1'b0;
      ate_q <= 1'b0;
      ie_q  <= 1'b0;
      ps_q  <= 3'h0;
    end else if (wr_ctrl) begin
      en_q  <= reg_wdata[`CS_EN];
      ate_q <= reg_wdata[`CS_ATE];
      ie_q  <= reg_wdata[`CS_IE];
      ps_q  <= reg_wdata[`CS_PS_HI:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_q  <= 2'h0;
      left_q <= 1'b0;
      sel_q  <= 5'h00;
    end else if (wr_mux) begin
      ref_q  <= reg_wdata[`MX_REF_HI:`MX_REF_LO];
      left_q <= reg_wdata[`MX_LEFT];
      sel_q  <= reg_wdata[`MX_SEL_HI:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aref_q <= 1'b0;
      tsel_q <= 3'h0;
    end else begin
      if (wr_misc) begin
        aref_q <= reg_wdata[`MISC_AREF];
      end
      if (wr_trig) begin
        tsel_q <= reg_wdata[`TRIG_HI:0];
      end
    end
  end

  // ==========================================================
  // prescaler
  always_ff @(posedge clk_sys) begin
    if (rst || !en_q) begin
      pre_q     <= '0;
      conv_tick <= 1'b0;
    end else if (pre_q >= div_last(ps_q)) begin
      pre_q     <= '0;
      conv_tick <= 1'b1;
    end else begin
      pre_q     <= pre_q + `PS_W'(1);
      conv_tick <= 1'b0;
    end
  end

  // ==========================================================
  // triggers and sequencer
  assign end_conv  = !idle && conv_tick && (cnt_q == (conv_long ? `LEN_LONG : `LEN_NORMAL) - 5'h1);
  assign apply_now = idle || end_conv;
  assign ref_differs = apply_now && (ref_q != act_ref_q);
  assign trig_level = trig_in[tsel_q];
  // free running code makes no edge
  assign trig_edge  = trig_level && !trig_prev_q && (tsel_q != `TRIG_FREE);
  assign start_sw   = wr_ctrl && reg_wdata[`CS_START] && reg_wdata[`CS_EN] && idle;
  assign start_trig = ate_q && en_q && trig_edge && idle && !wr_ctrl;
  assign start_free = end_conv && ate_q && (tsel_q == `TRIG_FREE) && en_d;
  assign start_any  = start_sw || start_trig || start_free;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 5'h00;
      conv_long <= 1'b0;
    end else if (!en_d) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
    end else if (start_any) begin
      state_q   <= ST_CONV;
      cnt_q     <= 5'h00;
      conv_long <= first_q || ref_chg_q || ref_differs;
    end else if (end_conv) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
    end else if (!idle && conv_tick) begin
      cnt_q <= cnt_q + 5'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_q <= 1'b1;
    end else if (!en_d) begin
      // next-value enable, so a start written with the enable clears the marker
      first_q <= 1'b1;
    end else if (start_any) begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_chg_q <= 1'b0;
    end else if (start_any) begin
      ref_chg_q <= 1'b0;
    end else if (ref_differs) begin
      ref_chg_q <= 1'b1;
    end
  end

  // settings move to the core only between conversions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_ref_q  <= 2'h0;
      analog_sel <= decode_sel(2'h0, 1'b0, 5'h00);
    end else if (apply_now) begin
      act_ref_q  <= ref_q;
      analog_sel <= decode_sel(ref_q, aref_q, sel_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_power <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      conv_power <= en_q;
      conv_busy  <= !idle;
    end
  end

  // ==========================================================
  // result and done flag
  // a result finishing while locked is dropped, matching the pairing guarantee
  assign lock_blocks = lock_q || (reg_rd && reg_addr == `OFS_RES_LO);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= 10'h000;
    end else if (end_conv && en_d && !lock_blocks) begin
      result_q <= core_result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (reg_rd && reg_addr == `OFS_RES_LO) begin
      lock_q <= 1'b1;
    end else if (reg_rd && reg_addr == `OFS_RES_HI) begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (end_conv && en_d) begin
      done_q <= 1'b1;
    end else if (irq_ack || (wr_ctrl && reg_wdata[`CS_DONE])) begin
      // clear by ack or write one
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= done_q && ie_q && irq_global_en;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= `REG_RESET;
    end else begin
      unique case (reg_addr)
        `OFS_RES_LO: reg_rdata <= left_q ? {result_q[1:0], 6'h00} : result_q[7:0];
        `OFS_RES_HI: reg_rdata <= left_q ? result_q[9:2] : {6'h00, result_q[9:8]};
        `OFS_CTRL:   reg_rdata <= {en_q, !idle, ate_q, done_q, ie_q, ps_q};
        `OFS_TRIG:   reg_rdata <= {5'h00, tsel_q};
        `OFS_MUX:    reg_rdata <= {ref_q, left_q, sel_q};
        `OFS_MISC:   reg_rdata <= {5'h00, aref_q, 2'h0};
        default:     reg_rdata <= `REG_RESET;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_finish;
    end_conv && en_d;
  endsequence

  a_done_after_end: assert property (s_finish |=> done_q)
    else $error("done flag not set after conversion end");
  a_busy_reads_one: assert property (
    (reg_rd && reg_addr == `OFS_CTRL && !idle) |=> reg_rdata[`CS_START])
    else $error("start bit not reading busy");
  a_abort_disable: assert property ((wr_ctrl && !reg_wdata[`CS_EN]) |=> idle)
    else $error("conversion not aborted on disable");
  a_irq_gate: assert property (
    (done_q && ie_q && irq_global_en) |=> irq_req)
    else $error("interrupt not requested");
  a_irq_masked: assert property (!ie_q |=> !irq_req)
    else $error("interrupt raised while masked");
  a_ack_clears: assert property (
    (irq_ack && !(end_conv && en_d)) |=> !done_q)
    else $error("acknowledge did not clear done flag");
  a_first_long: assert property ((start_any && first_q) |=> conv_long)
    else $error("first conversion not long");
  a_ref_deferred: assert property (
    (!idle && !end_conv) |=> $stable(act_ref_q))
    else $error("reference changed mid conversion");
  a_sel_deferred: assert property (
    (!idle && !end_conv) |=> $stable(analog_sel))
    else $error("input select changed mid conversion");
  a_lock_holds: assert property (
    (lock_q && !(reg_rd && reg_addr == `OFS_RES_HI)) |=> $stable(result_q))
    else $error("result changed while locked");
  a_free_no_trig: assert property ((tsel_q == `TRIG_FREE) |-> !start_trig)
    else $error("free running code triggered");
  a_pre_off: assert property (!en_q |=> (pre_q == '0) && !conv_tick)
    else $error("prescaler ran while off");
  a_div_two: assert property (
    (en_q && ps_q == 3'h2 && conv_tick) ##1 (en_q && ps_q == 3'h2)[*3]
    |=> conv_tick)
    else $error("divide by four period wrong");

endmodule : adc_control_registers

// >>> sim/conv_core_model.sv
// behavioural model of the multiplexer and conversion core
module conv_core_model
  import adc_ctrl_pkg::*;
(
  // control from the block
  input  wire logic        clk_sys,
  input  wire analog_sel_t analog_sel,
  input  wire logic        conv_power,
  input  wire logic        conv_busy,
  // result to the block
  output logic [9:0]       core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_q = 1'b0;
  always @(posedge clk_sys) flip_q <= ~flip_q;
  // outside a conversion the result lines wander, so a late sample is caught
  always_comb begin
    if (conv_power && conv_busy) core_result = {analog_sel.pos_pin, 6'h2d};
    else core_result = {5{flip_q, ~flip_q}};
  end
endmodule : conv_core_model

// >>> sim/adc_control_registers_tb.sv
// self-checking bench for the converter control block
`include "adc_ctrl_defines.svh"
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); \
  end \
end
module adc_control_registers_tb
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, trig_in = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, irq_global_en = 1'b0, irq_ack = 1'b0;
  logic        irq_req, conv_power, conv_tick, conv_busy, conv_long;
  logic [9:0]  core_result;
  analog_sel_t analog_sel;
  logic [3:0]  ptab [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  int          error_cnt = 0, samples_checked = 0, c, n, k, g;
  always #50 clk_sys = ~clk_sys;
  adc_control_registers adc_control_registers_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_global_en(irq_global_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .trig_in(trig_in), .core_result(core_result), .analog_sel(analog_sel),
    .conv_power(conv_power), .conv_tick(conv_tick), .conv_busy(conv_busy),
    .conv_long(conv_long)
  );
  conv_core_model conv_core_model_i (
    .clk_sys(clk_sys), .analog_sel(analog_sel), .conv_power(conv_power),
    .conv_busy(conv_busy), .core_result(core_result)
  );
  // ========
  // bus and sequencing tasks
  // a spare edge after each write keeps the strobe from being set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %0h", a), e, reg_rdata)
    @(posedge clk_sys);
  endtask : rdchk
  // busy lags the sequencer by one edge, so a tick counts when busy shows at the next edge
  task automatic run_conv(output int t);
    bit seen, tk;
    seen = 0;
    tk = (conv_tick === 1'b1);
    t = 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_sys);
      if (conv_busy === 1'b1) begin
        seen = 1;
        if (tk) t++;
      end else if (seen) break;
      tk = (conv_tick === 1'b1);
    end
  endtask : run_conv
  task automatic wait_busy(input int lim);
    for (k = 0; k < lim && conv_busy !== 1'b1; k++) @(posedge clk_sys);
  endtask : wait_busy
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin : watchdog
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
  // ========
  // test sequence
  initial begin : main
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wr(8'h70, 8'hff);
    rdchk(8'h70, 8'h00);
    rdchk(`OFS_CTRL, 8'h00);
    rdchk(`OFS_MUX, 8'h00);
    for (c = 0; c < 32; c++) begin
      wr(`OFS_MUX, 8'(c));
      repeat (2) @(posedge clk_sys);
      `CHK("diff", c[4], analog_sel.diff)
      if (c[4]) begin
        `CHK("gain", c[0], analog_sel.gain_20x)
        `CHK("pos", ptab[c[3:1]], analog_sel.pos_pin)
        `CHK("neg", ptab[c[3:1]] + 4'h1, analog_sel.neg_pin)
      end else begin
        `CHK("src", (c < 11) ? SRC_PIN : src_t'(3'(c - 10)), analog_sel.src)
        if (c < 11) `CHK("pin", c[3:0], analog_sel.pos_pin)
      end
    end
    for (c = 0; c < 8; c++) begin
      wr(`OFS_MISC, c[0] ? 8'h04 : 8'h00);
      wr(`OFS_MUX, {c[2:1], 6'h05});
      repeat (2) @(posedge clk_sys);
      `CHK("vref", (!c[1] ? (c[0] ? REF_EXT : REF_SUPPLY) : (c[2] ? REF_INT256 : REF_INT11)), analog_sel.vref)
    end
    wr(`OFS_MISC, 8'h00);
    wr(`OFS_MUX, 8'h05);
    for (c = 0; c < 8; c++) begin
      wr(`OFS_CTRL, 8'h80 | 8'(c));
      for (k = 0; k < 300 && conv_tick !== 1'b1; k++) @(posedge clk_sys);
      @(posedge clk_sys);
      g = 1;
      for (k = 0; k < 300 && conv_tick !== 1'b1; k++) begin
        @(posedge clk_sys);
        g++;
      end
      `CHK("tick gap", (c < 2) ? 2 : (1 << c), g)
      wr(`OFS_CTRL, 8'h00);
    end
    g = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (conv_tick !== 1'b0) g++;
    end
    `CHK("ticks off", 0, g)
    `CHK("power off", 1'b0, conv_power)
    wr(`OFS_CTRL, 8'hc2);
    run_conv(n);
    `CHK("first length", 25, n)
    `CHK("long flag", 1'b1, conv_long)
    `CHK("power on", 1'b1, conv_power)
    rdchk(`OFS_CTRL, 8'h92);
    rdchk(`OFS_RES_LO, 8'h6d);
    rdchk(`OFS_RES_HI, 8'h01);
    wr(`OFS_MUX, 8'h25);
    rdchk(`OFS_RES_HI, 8'h5b);
    rdchk(`OFS_RES_LO, 8'h40);
    wr(`OFS_MUX, 8'h29);
    rdchk(`OFS_MUX, 8'h29);
    wr(`OFS_CTRL, 8'hd2);
    run_conv(n);
    `CHK("normal length", 13, n)
    `CHK("short flag", 1'b0, conv_long)
    rdchk(`OFS_RES_HI, 8'h5b);
    rdchk(`OFS_CTRL, 8'h92);
    wr(`OFS_CTRL, 8'h8a);
    repeat (3) @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq_req)
    irq_global_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("irq", 1'b1, irq_req)
    irq_ack <= 1'b1;
    @(posedge clk_sys);
    irq_ack <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("irq taken", 1'b0, irq_req)
    rdchk(`OFS_CTRL, 8'h8a);
    wr(`OFS_CTRL, 8'hca);
    run_conv(n);
    rdchk(`OFS_CTRL, 8'h9a);
    // writing the flag back as one drops the pending request
    wr(`OFS_CTRL, 8'h9a);
    rdchk(`OFS_CTRL, 8'h8a);
    wr(`OFS_CTRL, 8'hc2);
    rdchk(`OFS_CTRL, 8'hc2);
    wr(`OFS_MUX, 8'hc3);
    repeat (3) @(posedge clk_sys);
    `CHK("vref held", REF_SUPPLY, analog_sel.vref)
    `CHK("pin held", 4'h9, analog_sel.pos_pin)
    run_conv(n);
    @(posedge clk_sys);
    `CHK("vref late", REF_INT256, analog_sel.vref)
    `CHK("pin late", 4'h3, analog_sel.pos_pin)
    wr(`OFS_CTRL, 8'hd2);
    run_conv(n);
    `CHK("length after ref change", 25, n)
    wr(`OFS_CTRL, 8'hd2);
    repeat (20) @(posedge clk_sys);
    wr(`OFS_CTRL, 8'h02);
    repeat (3) @(posedge clk_sys);
    `CHK("aborted", 1'b0, conv_busy)
    rdchk(`OFS_CTRL, 8'h02);
    wr(`OFS_TRIG, 8'h03);
    rdchk(`OFS_TRIG, 8'h03);
    wr(`OFS_CTRL, 8'ha2);
    trig_in <= 8'h08;
    wait_busy(10);
    `CHK("triggered", 1'b1, conv_busy)
    run_conv(n);
    trig_in <= 8'h00;
    wr(`OFS_TRIG, 8'h00);
    wait_busy(40);
    `CHK("no trigger", 1'b0, conv_busy)
    wr(`OFS_CTRL, 8'he2);
    repeat (300) @(posedge clk_sys);
    rdchk(`OFS_CTRL, 8'hf2);
    wr(`OFS_CTRL, 8'h00);
    print_verdict();
  end
endmodule : adc_control_registers_tb
